// ===== hdl/dtpm_pkg.sv
// constants shared by the dual timer block
package dtpm_pkg;
    // special-function register addresses
    localparam logic [7:0] ADDR_RUN_FLAG = 8'h88;
    localparam logic [7:0] ADDR_MODE = 8'h89;
    localparam logic [7:0] ADDR_T0_LOW = 8'h8A;
    localparam logic [7:0] ADDR_T1_LOW = 8'h8B;
    localparam logic [7:0] ADDR_T0_HIGH = 8'h8C;
    localparam logic [7:0] ADDR_T1_HIGH = 8'h8D;
    localparam logic [7:0] ADDR_CLK_SEL = 8'h8E;
    // values after reset
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // clock select register fields
    localparam int CKS_DIV_LSB = 0;
    localparam int CKS_T0_SYS = 2;
    localparam int CKS_T1_SYS = 3;
    localparam int CKS_T2_LOW = 4;
    localparam int CKS_T2_HIGH = 5;
    localparam int CKS_T3_LOW = 6;
    localparam int CKS_T3_HIGH = 7;
    // run/flag register fields
    localparam int RF_T0_RUN = 4;
    localparam int RF_T0_FLAG = 5;
    localparam int RF_T1_RUN = 6;
    localparam int RF_T1_FLAG = 7;
    // mode register fields
    localparam int MD_T0_LSB = 0;
    localparam int MD_T0_CT = 2;
    localparam int MD_T0_GATE = 3;
    localparam int MD_T1_LSB = 4;
    localparam int MD_T1_CT = 6;
    localparam int MD_T1_GATE = 7;
    // prescaler choice codes and terminal counts (divisor minus one)
    localparam logic [1:0] DIV_BY_12 = 2'h0;
    localparam logic [1:0] DIV_BY_4 = 2'h1;
    localparam logic [1:0] DIV_BY_48 = 2'h2;
    localparam logic [1:0] DIV_EXT_8 = 2'h3;
    localparam logic [5:0] LAST_12 = 6'h0B;
    localparam logic [5:0] LAST_4 = 6'h03;
    localparam logic [5:0] LAST_48 = 6'h2F;
    localparam logic [2:0] LAST_EXT = 3'h7;
    // timer modes
    localparam logic [1:0] MODE_13BIT = 2'h0;
    localparam logic [1:0] MODE_16BIT = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;
endpackage : dtpm_pkg

// ===== hdl/dtpm_timers.sv
// timer 0/1 counters, shared prescaler and clock-select register
// Operation
// - prescaler divides by 12, 4, 48, ext/8
// - clock pick chooses sysclk or prescaler ticks
// - timer 2 byte clock picks at bits 5,4
// - timer 3 byte clock picks at bits 7,6
// - counter mode counts falling pin edges
// - count only when run and gate allow
// - mode 0 is high byte plus five bits
// - mode 0 wrap sets overflow flag
// - run bit never clears the count
// - mode 1 is full sixteen bit count
// - mode 2 reloads low from high on wrap
// - split low byte uses timer 0 controls
// - split high byte: internal clock, timer1 run/flag
// - split: timer 1 no edges, no flag
// - timer 1 overflow pulse stays available
// - split: timer 1 runs unless mode 3
// - timer 1 mirrors timer 0 with own controls
// - interrupt request needs its enable bit
// - each timer has independent settings
// - mode codes: 13bit, 16bit, reload, split
// - flag set by hardware, cleared by software/vector
`timescale 1ns/1ns
module dtpm_timers (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // special-function register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // pins
    input wire logic count_pin_zero,
    input wire logic count_pin_one,
    input wire logic gate_input_zero,
    input wire logic gate_input_one,
    input wire logic ext_clock,
    // settings held in interrupt logic
    input wire logic gate_zero_polarity,
    input wire logic gate_one_polarity,
    input wire logic timer0_irq_enable,
    input wire logic timer1_irq_enable,
    input wire logic timer0_vector_ack,
    input wire logic timer1_vector_ack,
    // results
    output logic timer0_irq_req,
    output logic timer1_irq_req,
    output logic timer1_overflow_pulse,
    output logic timer2_high_clock_pick,
    output logic timer2_low_clock_pick,
    output logic timer3_high_clock_pick,
    output logic timer3_low_clock_pick
);
    typedef struct packed {
        logic [7:0] timer_clock_select;
        logic [7:0] timer_run_flag_reg;
        logic [7:0] timer_mode_reg;
        logic [7:0] timer0_low_byte;
        logic [7:0] timer0_high_byte;
        logic [7:0] timer1_low_byte;
        logic [7:0] timer1_high_byte;
        logic [5:0] presc_cnt;
        logic [2:0] ext_cnt;
        logic presc_tick;
        logic [2:0] pin0_sync;
        logic [2:0] pin1_sync;
        logic [2:0] ext_sync;
        logic [1:0] timer0_gate_enable_sync;
        logic [1:0] timer1_gate_enable_sync;
        logic [7:0] rdata;
        logic irq0;
        logic irq1;
        logic t1_ovf;
    } dtpm_state_t;

    dtpm_state_t s;
    dtpm_state_t next_s;

    // one count step for modes 0..2; mode 3 of a whole timer holds
    function automatic logic [16:0] dtpm_step(input logic [1:0] mode,
                                             input logic [7:0] lo,
                                             input logic [7:0] hi);
        logic [12:0] v13;
        logic [15:0] v16;
        logic [7:0] v8;
        v13 = {hi, lo[4:0]} + 13'h0001;
        v16 = {hi, lo} + 16'h0001;
        v8 = lo + 8'h01;
        case (mode)
            dtpm_pkg::MODE_13BIT: begin
                // upper low-byte bits are left alone; not part of count
                dtpm_step = {&{hi, lo[4:0]}, v13[12:5], lo[7:5], v13[4:0]};
            end
            dtpm_pkg::MODE_16BIT: begin
                dtpm_step = {&{hi, lo}, v16};
            end
            dtpm_pkg::MODE_RELOAD: begin
                dtpm_step = (&lo) ? {1'b1, hi, hi} : {1'b0, hi, v8};
            end
            default: begin
                dtpm_step = {1'b0, hi, lo};
            end
        endcase
    endfunction : dtpm_step

    // decoded controls and ticks, visible to checks
    logic [1:0] div_choice;
    logic [1:0] mode0;
    logic [1:0] mode1;
    logic split;
    logic edge0;
    logic edge1;
    logic ext_rise;
    logic run0;
    logic run1;
    logic tick0;
    logic tick1;
    logic high_tick;
    logic ovf0;
    logic ovf_high;
    logic ovf1;
    logic [16:0] step0;
    logic [16:0] step1;

    assign div_choice = s.timer_clock_select[dtpm_pkg::CKS_DIV_LSB +: 2];
    assign mode0 = s.timer_mode_reg[dtpm_pkg::MD_T0_LSB +: 2];
    assign mode1 = s.timer_mode_reg[dtpm_pkg::MD_T1_LSB +: 2];
    assign split = mode0 == dtpm_pkg::MODE_SPLIT;
    // edge detectors look only at the second and third stages
    assign edge0 = s.pin0_sync[2] & ~s.pin0_sync[1];
    assign edge1 = s.pin1_sync[2] & ~s.pin1_sync[1];
    assign ext_rise = s.ext_sync[1] & ~s.ext_sync[2];
    assign run0 = s.timer_run_flag_reg[dtpm_pkg::RF_T0_RUN]
        & (~s.timer_mode_reg[dtpm_pkg::MD_T0_GATE]
        | (s.timer0_gate_enable_sync[1] == gate_zero_polarity));
    // in split mode timer 1 is started and stopped by its mode field
    assign run1 = split ? (mode1 != dtpm_pkg::MODE_SPLIT)
        : s.timer_run_flag_reg[dtpm_pkg::RF_T1_RUN]
        & (~s.timer_mode_reg[dtpm_pkg::MD_T1_GATE]
        | (s.timer1_gate_enable_sync[1] == gate_one_polarity));
    assign tick0 = s.timer_mode_reg[dtpm_pkg::MD_T0_CT] ? edge0
        : (s.timer_clock_select[dtpm_pkg::CKS_T0_SYS]
        | s.presc_tick);
    assign tick1 = (s.timer_mode_reg[dtpm_pkg::MD_T1_CT] & ~split)
        ? edge1
        : (s.timer_clock_select[dtpm_pkg::CKS_T1_SYS] | s.presc_tick);
    assign high_tick = s.timer_clock_select[dtpm_pkg::CKS_T0_SYS]
        | s.presc_tick;
    assign step0 = dtpm_step(mode0, s.timer0_low_byte,
                             s.timer0_high_byte);
    assign step1 = dtpm_step(mode1, s.timer1_low_byte,
                             s.timer1_high_byte);
    assign ovf0 = run0 & tick0 & (split ? (&s.timer0_low_byte) : step0[16]);
    assign ovf_high = split & s.timer_run_flag_reg[dtpm_pkg::RF_T1_RUN]
        & high_tick & (&s.timer0_high_byte);
    assign ovf1 = run1 & tick1 & step1[16];

    always_comb begin
        logic [5:0] last;
        logic flag0;
        logic flag1;
        last = dtpm_pkg::LAST_12;
        flag0 = s.timer_run_flag_reg[dtpm_pkg::RF_T0_FLAG];
        flag1 = s.timer_run_flag_reg[dtpm_pkg::RF_T1_FLAG];
        next_s = s;
        next_s.pin0_sync = {s.pin0_sync[1:0], count_pin_zero};
        next_s.pin1_sync = {s.pin1_sync[1:0], count_pin_one};
        next_s.ext_sync = {s.ext_sync[1:0], ext_clock};
        next_s.timer0_gate_enable_sync = {s.timer0_gate_enable_sync[0], gate_input_zero};
        next_s.timer1_gate_enable_sync = {s.timer1_gate_enable_sync[0], gate_input_one};
        // prescaler, one-cycle tick out
        case (div_choice)
            dtpm_pkg::DIV_BY_4: begin
                last = dtpm_pkg::LAST_4;
            end
            dtpm_pkg::DIV_BY_48: begin
                last = dtpm_pkg::LAST_48;
            end
            default: begin
                last = dtpm_pkg::LAST_12;
            end
        endcase
        next_s.presc_tick = 1'b0;
        if (div_choice == dtpm_pkg::DIV_EXT_8) begin
            next_s.presc_cnt = 6'h00;
            if (ext_rise) begin
                next_s.ext_cnt = s.ext_cnt + 3'h1;
                next_s.presc_tick = s.ext_cnt == dtpm_pkg::LAST_EXT;
            end
        end else if (s.presc_cnt >= last) begin
            // a smaller divisor chosen mid-count restarts at once
            next_s.presc_cnt = 6'h00;
            next_s.presc_tick = 1'b1;
        end else begin
            next_s.presc_cnt = s.presc_cnt + 6'h01;
        end
        // timer 0, or its low byte in split mode
        if (run0 & tick0) begin
            if (split) begin
                next_s.timer0_low_byte = s.timer0_low_byte + 8'h01;
            end else begin
                next_s.timer0_low_byte = step0[7:0];
                next_s.timer0_high_byte = step0[15:8];
            end
        end
        if (split & s.timer_run_flag_reg[dtpm_pkg::RF_T1_RUN] & high_tick)
        begin
            next_s.timer0_high_byte = s.timer0_high_byte + 8'h01;
        end
        if (run1 & tick1) begin
            next_s.timer1_low_byte = step1[7:0];
            next_s.timer1_high_byte = step1[15:8];
        end
        next_s.t1_ovf = ovf1;
        // flags: vector or software clears, hardware set wins
        if (timer0_vector_ack) begin
            flag0 = 1'b0;
        end
        if (timer1_vector_ack) begin
            flag1 = 1'b0;
        end
        if (sfr_wr) begin
            case (sfr_addr)
                dtpm_pkg::ADDR_CLK_SEL: begin
                    next_s.timer_clock_select = sfr_wdata;
                end
                dtpm_pkg::ADDR_RUN_FLAG: begin
                    next_s.timer_run_flag_reg = sfr_wdata;
                    flag0 = sfr_wdata[dtpm_pkg::RF_T0_FLAG];
                    flag1 = sfr_wdata[dtpm_pkg::RF_T1_FLAG];
                end
                dtpm_pkg::ADDR_MODE: next_s.timer_mode_reg = sfr_wdata;
                dtpm_pkg::ADDR_T0_LOW: next_s.timer0_low_byte = sfr_wdata;
                dtpm_pkg::ADDR_T0_HIGH: next_s.timer0_high_byte = sfr_wdata;
                dtpm_pkg::ADDR_T1_LOW: next_s.timer1_low_byte = sfr_wdata;
                dtpm_pkg::ADDR_T1_HIGH: next_s.timer1_high_byte = sfr_wdata;
                default: ;
            endcase
        end
        if (ovf0) begin
            flag0 = 1'b1;
        end
        if (split ? ovf_high : ovf1) begin
            flag1 = 1'b1;
        end
        next_s.timer_run_flag_reg[dtpm_pkg::RF_T0_FLAG] = flag0;
        next_s.timer_run_flag_reg[dtpm_pkg::RF_T1_FLAG] = flag1;
        next_s.irq0 = s.timer_run_flag_reg[dtpm_pkg::RF_T0_FLAG]
            & timer0_irq_enable;
        next_s.irq1 = s.timer_run_flag_reg[dtpm_pkg::RF_T1_FLAG]
            & timer1_irq_enable;
        // read data is registered; unmapped addresses read zero
        next_s.rdata = 8'h00;
        if (sfr_rd) begin
            case (sfr_addr)
                dtpm_pkg::ADDR_CLK_SEL: next_s.rdata = s.timer_clock_select;
                dtpm_pkg::ADDR_RUN_FLAG: next_s.rdata = s.timer_run_flag_reg;
                dtpm_pkg::ADDR_MODE: next_s.rdata = s.timer_mode_reg;
                dtpm_pkg::ADDR_T0_LOW: next_s.rdata = s.timer0_low_byte;
                dtpm_pkg::ADDR_T0_HIGH: next_s.rdata = s.timer0_high_byte;
                dtpm_pkg::ADDR_T1_LOW: next_s.rdata = s.timer1_low_byte;
                dtpm_pkg::ADDR_T1_HIGH: next_s.rdata = s.timer1_high_byte;
                default: next_s.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign sfr_rdata = s.rdata;
    assign timer0_irq_req = s.irq0;
    assign timer1_irq_req = s.irq1;
    assign timer1_overflow_pulse = s.t1_ovf;
    assign timer2_high_clock_pick = s.timer_clock_select[dtpm_pkg::CKS_T2_HIGH];
    assign timer2_low_clock_pick = s.timer_clock_select[dtpm_pkg::CKS_T2_LOW];
    assign timer3_high_clock_pick = s.timer_clock_select[dtpm_pkg::CKS_T3_HIGH];
    assign timer3_low_clock_pick = s.timer_clock_select[dtpm_pkg::CKS_T3_LOW];

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_div4;
        (s.presc_tick && div_choice == dtpm_pkg::DIV_BY_4 && !sfr_wr)
            |=> (!s.presc_tick [*3]) ##1
            (s.presc_tick || $past(sfr_wr, 3) || $past(sfr_wr, 2));
    endproperty
    a_div4: assert property (p_div4)
        else $error("prescaler divide by 4 period wrong");

    property p_sys_count;
        (run0 && !s.timer_mode_reg[dtpm_pkg::MD_T0_CT] && !sfr_wr
            && s.timer_clock_select[dtpm_pkg::CKS_T0_SYS]
            && mode0 == dtpm_pkg::MODE_16BIT)
            |=> {s.timer0_high_byte, s.timer0_low_byte}
            == $past({s.timer0_high_byte, s.timer0_low_byte}) + 16'h0001;
    endproperty
    a_sys_count: assert property (p_sys_count)
        else $error("timer 0 missed a system clock count");

    property p_hold;
        (!s.timer_run_flag_reg[dtpm_pkg::RF_T0_RUN] && !sfr_wr)
            |=> $stable(s.timer0_low_byte);
    endproperty
    a_hold: assert property (p_hold)
        else $error("timer 0 low byte moved while stopped");

    property p_wrap13;
        (run0 && tick0 && mode0 == dtpm_pkg::MODE_13BIT
            && {s.timer0_high_byte, s.timer0_low_byte[4:0]} == 13'h1FFF)
            |=> s.timer_run_flag_reg[dtpm_pkg::RF_T0_FLAG]
            && (sfr_wr || s.timer0_high_byte == 8'h00 || $past(sfr_wr));
    endproperty
    a_wrap13: assert property (p_wrap13)
        else $error("13-bit wrap did not set flag");

    property p_reload;
        (run0 && tick0 && mode0 == dtpm_pkg::MODE_RELOAD && !sfr_wr
            && s.timer0_low_byte == 8'hFF)
            |=> s.timer0_low_byte == $past(s.timer0_high_byte)
            && $stable(s.timer0_high_byte);
    endproperty
    a_reload: assert property (p_reload)
        else $error("reload mode wrap did not copy high byte");

    property p_split_noflag;
        (split && !ovf_high && !sfr_wr)
            |=> !$rose(s.timer_run_flag_reg[dtpm_pkg::RF_T1_FLAG]);
    endproperty
    a_split_noflag: assert property (p_split_noflag)
        else $error("timer 1 flag set in split mode");

    property p_ack_clear;
        (timer0_vector_ack && !ovf0 && !sfr_wr)
            |=> !s.timer_run_flag_reg[dtpm_pkg::RF_T0_FLAG];
    endproperty
    a_ack_clear: assert property (p_ack_clear)
        else $error("vector acknowledge did not clear flag");

    property p_irq;
        ##1 timer0_irq_req == $past(
            s.timer_run_flag_reg[dtpm_pkg::RF_T0_FLAG] && timer0_irq_enable);
    endproperty
    a_irq: assert property (p_irq)
        else $error("timer 0 request not flag and enable");

    property p_edge_pulse;
        edge0 |=> !edge0;
    endproperty
    a_edge_pulse: assert property (p_edge_pulse)
        else $error("count edge lasted more than one cycle");
endmodule : dtpm_timers

// ===== sim/dtpm_pins.sv
// model of the external count, gate and clock pins
`timescale 1ns/1ns
module dtpm_pins (
    // clock
    input wire logic clk,
    // pins
    output logic count_pin_zero,
    output logic count_pin_one,
    output logic gate_input_zero,
    output logic gate_input_one,
    output logic ext_clock
);
    logic [2:0] idle_lvl;
    assign count_pin_zero = idle_lvl[0];
    assign count_pin_one = idle_lvl[1];
    // external clock rests low between bursts
    assign ext_clock = ~idle_lvl[2];
    initial begin
        idle_lvl = 3'h7;
        gate_input_zero = 1'b0;
        gate_input_one = 1'b0;
    end
    // three cycles per level: slower than a quarter of the clock rate
    task automatic pulse(input int which, input int n);
        repeat (n) begin
            repeat (3) @(negedge clk);
            idle_lvl[which] = 1'b0;
            repeat (3) @(negedge clk);
            idle_lvl[which] = 1'b1;
        end
    endtask : pulse
    task automatic gate(input logic g0, input logic g1);
        @(negedge clk);
        gate_input_zero = g0;
        gate_input_one = g1;
    endtask : gate
endmodule : dtpm_pins

// ===== sim/dual_timer_prescale_modes_bench.sv
// self-checking bench for the dual timer block
`timescale 1ns/1ns
module dual_timer_prescale_modes_bench;
    logic clk, reset_n, sfr_wr, sfr_rd;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rv, rv2;
    logic cp0, cp1, gi0, gi1, xclk, pol0, pol1;
    logic ien0, ien1, ack0, ack1, irq0, irq1, ovf1;
    logic [3:0] picks;
    int miscompares, check_count, ovf_seen;
    dtpm_timers dut (.clk(clk), .reset_n(reset_n), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .count_pin_zero(cp0), .count_pin_one(cp1),
        .gate_input_zero(gi0), .gate_input_one(gi1), .ext_clock(xclk),
        .gate_zero_polarity(pol0), .gate_one_polarity(pol1),
        .timer0_irq_enable(ien0), .timer1_irq_enable(ien1),
        .timer0_vector_ack(ack0), .timer1_vector_ack(ack1),
        .timer0_irq_req(irq0), .timer1_irq_req(irq1),
        .timer1_overflow_pulse(ovf1),
        .timer2_high_clock_pick(picks[1]), .timer2_low_clock_pick(picks[0]),
        .timer3_high_clock_pick(picks[3]), .timer3_low_clock_pick(picks[2]));
    dtpm_pins pins (.clk(clk), .count_pin_zero(cp0), .count_pin_one(cp1),
        .gate_input_zero(gi0), .gate_input_one(gi1), .ext_clock(xclk));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (ovf1 === 1'b1) ovf_seen++;
    end
    task automatic complete_run();
        if (miscompares == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [7:0] lo,
                       input logic [7:0] hi, input logic [7:0] got);
        check_count++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            miscompares++;
            $display("BAD %s expected %h..%h seen %h", nm, lo, hi, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
        d = sfr_rdata;
    endtask : rd
    task automatic rc(input string nm, input logic [7:0] a,
                      input logic [7:0] lo, input logic [7:0] hi);
        logic [7:0] d;
        rd(a, d);
        chk(nm, lo, hi, d);
    endtask : rc
    // load both bytes of a timer, low address given
    task automatic load(input logic [7:0] a, input logic [7:0] lo,
                        input logic [7:0] hi);
        wr(a, lo);
        wr(a + 8'h02, hi);
    endtask : load
    // runs for n + 4 clocks; stopping rewrites the flags as read so that
    // an overflow flag raised during the run survives the stop
    task automatic run_for(input logic [7:0] runs, input int n);
        logic [7:0] d;
        wr(dtpm_pkg::ADDR_RUN_FLAG, runs);
        repeat (n) @(negedge clk);
        rd(dtpm_pkg::ADDR_RUN_FLAG, d);
        wr(dtpm_pkg::ADDR_RUN_FLAG, d & ~runs);
    endtask : run_for
    task automatic t_reset_and_select();
        for (int a = 8'h88; a <= 8'h8E; a++) rc("reset", 8'(a), 8'h00, 8'h00);
        rc("unmapped", 8'h90, 8'h00, 8'h00);
        wr(dtpm_pkg::ADDR_CLK_SEL, 8'h50);
        @(negedge clk);
        chk("picks", 8'h05, 8'h05, {4'h0, picks});
        rc("clksel", dtpm_pkg::ADDR_CLK_SEL, 8'h50, 8'h50);
        wr(dtpm_pkg::ADDR_CLK_SEL, 8'hA0);
        @(negedge clk);
        chk("picks", 8'h0A, 8'h0A, {4'h0, picks});
    endtask : t_reset_and_select
    task automatic t_prescale();
        logic [7:0] exp [4] = '{8'd40, 8'd120, 8'd10, 8'd10};
        wr(dtpm_pkg::ADDR_MODE, 8'h01);
        for (int c = 0; c < 4; c++) begin
            wr(dtpm_pkg::ADDR_CLK_SEL, 8'(c));
            load(dtpm_pkg::ADDR_T0_LOW, 8'h00, 8'h00);
            wr(dtpm_pkg::ADDR_RUN_FLAG, 8'h10);
            if (c == 3) pins.pulse(2, 80);
            else repeat (480) @(negedge clk);
            wr(dtpm_pkg::ADDR_RUN_FLAG, 8'h00);
            rc("prescale", dtpm_pkg::ADDR_T0_LOW, exp[c] - 8'h01,
               exp[c] + 8'h01);
        end
    endtask : t_prescale
    task automatic t_mode0_wrap();
        wr(dtpm_pkg::ADDR_CLK_SEL, 8'h04);
        wr(dtpm_pkg::ADDR_MODE, 8'h00);
        load(dtpm_pkg::ADDR_T0_LOW, 8'h1C, 8'hFF);
        ien0 = 1'b1;
        run_for(8'h10, 10);
        rd(dtpm_pkg::ADDR_T0_LOW, rv);
        chk("m0 low", 8'h05, 8'h0A, rv & 8'h1F);
        rc("m0 high", dtpm_pkg::ADDR_T0_HIGH, 8'h00, 8'h00);
        rc("m0 flag", dtpm_pkg::ADDR_RUN_FLAG, 8'h20, 8'h20);
        chk("irq0", 8'h01, 8'h01, {7'h0, irq0});
        ien0 = 1'b0;
        repeat (2) @(negedge clk);
        chk("irq0 masked", 8'h00, 8'h00, {7'h0, irq0});
        ack0 = 1'b1;
        @(negedge clk);
        ack0 = 1'b0;
        rc("ack clear", dtpm_pkg::ADDR_RUN_FLAG, 8'h00, 8'h00);
    endtask : t_mode0_wrap
    task automatic t_counter_gate();
        wr(dtpm_pkg::ADDR_MODE, 8'h05);
        load(dtpm_pkg::ADDR_T0_LOW, 8'h00, 8'h00);
        wr(dtpm_pkg::ADDR_RUN_FLAG, 8'h10);
        pins.pulse(0, 5);
        wr(dtpm_pkg::ADDR_RUN_FLAG, 8'h00);
        rc("edges", dtpm_pkg::ADDR_T0_LOW, 8'h05, 8'h05);
        wr(dtpm_pkg::ADDR_RUN_FLAG, 8'h10);
        pins.pulse(0, 3);
        wr(dtpm_pkg::ADDR_RUN_FLAG, 8'h00);
        rc("resume", dtpm_pkg::ADDR_T0_LOW, 8'h08, 8'h08);
        wr(dtpm_pkg::ADDR_MODE, 8'h09);
        load(dtpm_pkg::ADDR_T0_LOW, 8'h00, 8'h00);
        run_for(8'h10, 20);
        rc("gated", dtpm_pkg::ADDR_T0_LOW, 8'h00, 8'h00);
        pins.gate(1'b1, 1'b0);
        repeat (3) @(negedge clk);
        run_for(8'h10, 20);
        rc("gate open", dtpm_pkg::ADDR_T0_LOW, 8'h18, 8'h18);
        pins.gate(1'b0, 1'b0);
    endtask : t_counter_gate
    task automatic t_reload_and_timer1();
        wr(dtpm_pkg::ADDR_MODE, 8'h02);
        load(dtpm_pkg::ADDR_T0_LOW, 8'hFC, 8'hF0);
        run_for(8'h10, 10);
        rc("reload", dtpm_pkg::ADDR_T0_LOW, 8'hFA, 8'hFA);
        rc("reload hi", dtpm_pkg::ADDR_T0_HIGH, 8'hF0, 8'hF0);
        rc("m2 flag", dtpm_pkg::ADDR_RUN_FLAG, 8'h20, 8'h20);
        wr(dtpm_pkg::ADDR_RUN_FLAG, 8'h00);
        wr(dtpm_pkg::ADDR_CLK_SEL, 8'h08);
        wr(dtpm_pkg::ADDR_MODE, 8'h12);
        load(dtpm_pkg::ADDR_T1_LOW, 8'hF8, 8'hFF);
        ien1 = 1'b1;
        run_for(8'h40, 20);
        rc("t1 flag", dtpm_pkg::ADDR_RUN_FLAG, 8'h80, 8'h80);
        chk("irq1", 8'h01, 8'h01, {7'h0, irq1});
        rc("t0 idle", dtpm_pkg::ADDR_T0_HIGH, 8'hF0, 8'hF0);
        wr(dtpm_pkg::ADDR_RUN_FLAG, 8'h00);
    endtask : t_reload_and_timer1
    task automatic t_split();
        wr(dtpm_pkg::ADDR_CLK_SEL, 8'h0C);
        wr(dtpm_pkg::ADDR_MODE, 8'h33);
        load(dtpm_pkg::ADDR_T0_LOW, 8'h00, 8'hFE);
        run_for(8'h40, 20);
        rc("split low", dtpm_pkg::ADDR_T0_LOW, 8'h00, 8'h00);
        rc("split high", dtpm_pkg::ADDR_T0_HIGH, 8'h10, 8'h16);
        rc("split flag", dtpm_pkg::ADDR_RUN_FLAG, 8'h80, 8'h80);
        wr(dtpm_pkg::ADDR_RUN_FLAG, 8'h00);
        load(dtpm_pkg::ADDR_T1_LOW, 8'h1C, 8'hFF);
        ovf_seen = 0;
        wr(dtpm_pkg::ADDR_MODE, 8'h43);
        pins.pulse(1, 2);
        rc("t1 no flag", dtpm_pkg::ADDR_RUN_FLAG, 8'h00, 8'h00);
        chk("t1 pulse", 8'h01, 8'hFF, 8'(ovf_seen));
        wr(dtpm_pkg::ADDR_MODE, 8'h73);
        rd(dtpm_pkg::ADDR_T1_LOW, rv);
        repeat (10) @(negedge clk);
        rd(dtpm_pkg::ADDR_T1_LOW, rv2);
        chk("t1 stop", rv, rv, rv2);
    endtask : t_split
    initial begin
        miscompares = 0;
        check_count = 0;
        reset_n = 1'b0;
        {sfr_wr, sfr_rd, ack0, ack1, ien0, ien1, pol1} = 7'h00;
        pol0 = 1'b1;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        t_reset_and_select();
        t_prescale();
        t_mode0_wrap();
        t_counter_gate();
        t_reload_and_timer1();
        t_split();
        complete_run();
    end
    // the whole sequence needs well under ten thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        complete_run();
    end
endmodule : dual_timer_prescale_modes_bench
